// file: src/amp_fault_params.svh
`ifndef AMP_FAULT_PARAMS_SVH
`define AMP_FAULT_PARAMS_SVH

// Detector hysteresis: a raw level must hold this long to be believed
`define OC_HYST_NS        200
`define CLK_PERIOD_NS     50
`define OC_HYST_CYC       ((`OC_HYST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Gain reducer timing
`define AGC_STEP_NS       1000
`define AGC_STEP_CYC      (`AGC_STEP_NS / `CLK_PERIOD_NS)
`define AGC_REL_CYC       4000
`define AGC_MAX_STEP      7

// Thermal warning attenuation floor step
`define THERM_WARN_STEP   2

// Initialisation length after reset release, in cycles
`define INIT_CYC          64

`endif

// file: src/amp_fault_pkg.sv
package amp_fault_pkg;

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } prot_state_t;

endpackage

// file: src/oc_detector.sv
`timescale 1ns/1ps
`default_nettype none

`include "amp_fault_params.svh"

module oc_detector #(
  parameter int HYST = `OC_HYST_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Raw comparator level, already synchronised
  input  wire logic raw,
  // Filtered level
  output var  logic level
);

  localparam int CW = $clog2(HYST + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          level_q;
  logic          level_d;

  // ----------------------------------------------------------------------
  // Hysteresis filter
  // ----------------------------------------------------------------------
  // Switching spikes are shorter than HYST, so they never flip the level
  always_comb begin
    cnt_d   = cnt_q;
    level_d = level_q;
    if (raw == level_q) begin
      cnt_d = '0;
    end else if (cnt_q == CW'(HYST - 1)) begin
      cnt_d   = '0;
      level_d = raw;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule

`default_nettype wire

// file: src/amp_fault_protection.sv
// Behaviour
// - Low overcurrent drives channel fault line low only while it lasts.
// - High overcurrent latches stage shutdown (pin floats) and fault line.
// - Fault is reported on the line of the detecting channel.
// - Four fault lines: pulse for low, latched level for high threshold.
// - Detectors filter out short PWM switching transients with hysteresis.
// - Three sense inputs judged according to selected output mode.
// - During reset the shared pin is a configuration input.
// - After initialisation the shared pin is an active-low error output.
// - Shared pin driven low while bus master activity during initialisation.
// - Low thermal threshold raises warning and attenuates, no shutdown.
// - High thermal threshold latches shutdown of all stages, all faults low.
// - Sensed overload steps gain down, by event timing and persistence.
// - Short circuit, high temperature or undervoltage shut outputs down.
// - Operation blocked until all supplies are in limits.
// - Supply dropout shuts outputs and drives all four fault lines.
`timescale 1ns/1ps
`default_nettype none

`include "amp_fault_params.svh"

module amp_fault_protection
  import amp_fault_pkg::*;
#(
  parameter int NCH      = 4,
  parameter int NSENSE   = 3,
  parameter int INIT_CYC = `INIT_CYC,
  parameter int REL_CYC  = `AGC_REL_CYC
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Analog comparators: overcurrent per stage, temperature and supply
  input  wire logic [NCH-1:0]    oc_low,
  input  wire logic [NCH-1:0]    oc_high,
  input  wire logic              temp_warn,
  input  wire logic              temp_crit,
  input  wire logic              supply_ok,
  // Controller side
  input  wire logic [NCH-1:0]    pwm_enable,
  input  wire logic              bus_master_busy,
  input  wire logic              cfg_other,
  // Fault lines (active low) and their sense inputs
  output logic [NCH-1:0]         fault_out_lines_n,
  input  wire logic [NSENSE-1:0] fault_sense_group_n,
  // Shared error / configuration pin
  input  wire logic              shared_fault_cfg_pin_i,
  output logic                   shared_fault_cfg_pin_o,
  output logic                   shared_fault_cfg_pin_oe_n,
  // Stage control and status
  output logic [NCH-1:0]         stage_drive_en,
  output logic [1:0]             cfg_mode,
  output logic [2:0]             gain_step,
  output logic                   thermal_warn_flag
);

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  logic [2*NCH+2:0]  raw_a_q, raw_b_q;
  logic [NSENSE-1:0] sns_a_q, sns_b_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      raw_a_q <= {1'b1, {(2*NCH+2){1'b0}}}; // Idle levels, no false fault
      raw_b_q <= {1'b1, {(2*NCH+2){1'b0}}};
      sns_a_q <= '1;
      sns_b_q <= '1;
    end else begin
      raw_a_q <= {supply_ok, temp_crit, temp_warn, oc_high, oc_low};
      raw_b_q <= raw_a_q;
      sns_a_q <= fault_sense_group_n;
      sns_b_q <= sns_a_q;
    end
  end

  // ----------------------------------------------------------------------
  // Detector filters
  // ----------------------------------------------------------------------
  logic [NCH-1:0] lo_lvl, hi_lvl;

  for (genvar i = 0; i < NCH; i++) begin : g_det
    oc_detector u_lo (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .raw     (raw_b_q[i]),
      .level   (lo_lvl[i])
    );
    oc_detector u_hi (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .raw     (raw_b_q[NCH+i]),
      .level   (hi_lvl[i])
    );
  end

  logic warn_s, crit_s, sup_ok_s;
  assign warn_s   = raw_b_q[2*NCH];
  assign crit_s   = raw_b_q[2*NCH+1];
  assign sup_ok_s = raw_b_q[2*NCH+2];

  // ----------------------------------------------------------------------
  // Sequencing and latches
  // ----------------------------------------------------------------------
  prot_state_t    st_q, st_d;
  logic [15:0]    init_q, init_d;
  logic [1:0]     cfg_q, cfg_d;
  logic [NCH-1:0] hi_latch_q, hi_latch_d;
  logic           therm_q, therm_d;
  logic [NCH-1:0] fault_n_d, drive_d;
  logic           pin_o_d, pin_oe_n_d, pin_o_q, pin_oe_n_q;
  logic [NCH-1:0] fault_n_q, drive_q;
  logic           warn_q;

  always_comb begin
    st_d       = st_q;
    init_d     = init_q;
    cfg_d      = cfg_q;
    hi_latch_d = hi_latch_q;
    therm_d    = therm_q;
    unique case (st_q)
      ST_INIT: begin
        // First cycle after release: strap still reflects the pull
        cfg_d  = {shared_fault_cfg_pin_i, cfg_other};
        init_d = '0;
        st_d   = ST_WAIT;
      end
      ST_WAIT: begin
        if (!sup_ok_s) begin
          init_d = '0;
        end else if (init_q == 16'(INIT_CYC - 1)) begin
          st_d = ST_RUN;
        end else begin
          init_d = init_q + 16'h0001;
        end
      end
      ST_RUN: begin
        // Acknowledge takes priority only when no new event is present
        for (int i = 0; i < NCH; i++) begin
          if (hi_lvl[i]) begin
            hi_latch_d[i] = 1'b1;
          end else if (!pwm_enable[i]) begin
            hi_latch_d[i] = 1'b0;
          end
        end
        if (crit_s) begin
          therm_d = 1'b1;
        end else if (pwm_enable == '0) begin
          therm_d = 1'b0;
        end
        if (!sup_ok_s) begin
          st_d   = ST_WAIT;
          init_d = '0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------
  logic run;
  assign run = (st_q == ST_RUN);

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // Own channel line only; thermal or supply shutdown pulls all low
      fault_n_d[i] = !(lo_lvl[i] || hi_latch_q[i] || therm_q
                       || !sup_ok_s);
      drive_d[i]   = run && sup_ok_s && !hi_latch_q[i] && !therm_q
                     && pwm_enable[i];
    end
    pin_o_d    = 1'b0;
    pin_oe_n_d = 1'b1;
    if (run) begin
      pin_oe_n_d = !((|hi_latch_q) || therm_q);
    end else if (st_q == ST_WAIT) begin
      pin_oe_n_d = !bus_master_busy;
    end
  end

  // ----------------------------------------------------------------------
  // Gain reducer
  // ----------------------------------------------------------------------
  // Overload persisting a full step interval takes one more step; quiet
  // time releases one step. Mode picks which sense pins count.
  logic [NSENSE-1:0] sns_mask;
  logic              ovl;
  logic [2:0]        step_q, step_d;
  logic [15:0]       tmr_q, tmr_d;
  logic [15:0]       quiet_q, quiet_d;

  always_comb begin
    unique case (cfg_q)
      2'b00, 2'b01: sns_mask = 3'b011; // Third sense unused, tied high
      default:      sns_mask = 3'b111;
    endcase
    ovl     = run && |(~sns_b_q & sns_mask);
    step_d  = step_q;
    tmr_d   = tmr_q;
    quiet_d = quiet_q;
    if (ovl) begin
      quiet_d = '0;
      if (tmr_q == 16'(`AGC_STEP_CYC) || tmr_q == '0) begin
        if (step_q != 3'(`AGC_MAX_STEP)) begin
          step_d = step_q + 3'h1;
        end
        tmr_d = 16'h0001;
      end else begin
        tmr_d = tmr_q + 16'h0001;
      end
    end else begin
      tmr_d = '0;
      if (quiet_q == 16'(REL_CYC - 1)) begin
        quiet_d = '0;
        if (step_q != '0) begin
          step_d = step_q - 3'h1;
        end
      end else begin
        quiet_d = quiet_q + 16'h0001;
      end
    end
    if (warn_s && step_d < 3'(`THERM_WARN_STEP)) begin
      step_d = 3'(`THERM_WARN_STEP);
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q       <= ST_INIT;
      init_q     <= '0;
      cfg_q      <= '0;
      hi_latch_q <= '0;
      therm_q    <= 1'b0;
      fault_n_q  <= '1;
      drive_q    <= '0;
      pin_o_q    <= 1'b0;
      pin_oe_n_q <= 1'b1;
      warn_q     <= 1'b0;
      step_q     <= '0;
      tmr_q      <= '0;
      quiet_q    <= '0;
    end else begin
      st_q       <= st_d;
      init_q     <= init_d;
      cfg_q      <= cfg_d;
      hi_latch_q <= hi_latch_d;
      therm_q    <= therm_d;
      fault_n_q  <= fault_n_d;
      drive_q    <= drive_d;
      pin_o_q    <= pin_o_d;
      pin_oe_n_q <= pin_oe_n_d;
      warn_q     <= warn_s;
      step_q     <= step_d;
      tmr_q      <= tmr_d;
      quiet_q    <= quiet_d;
    end
  end

  assign fault_out_lines_n         = fault_n_q;
  assign stage_drive_en            = drive_q;
  assign shared_fault_cfg_pin_o    = pin_o_q;
  assign shared_fault_cfg_pin_oe_n = pin_oe_n_q;
  assign cfg_mode                  = cfg_q;
  assign gain_step                 = step_q;
  assign thermal_warn_flag         = warn_q;

endmodule

`default_nettype wire

// file: test/amp_fault_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Protection checker
// ----
module amp_fault_asserts #(
  parameter int NCH = 4
) (
  // Clock and reset
  input wire logic           clk_sys,
  input wire logic           rst_n,
  // Monitor and controller inputs
  input wire logic [NCH-1:0] oc_low,
  input wire logic [NCH-1:0] oc_high,
  input wire logic           temp_crit,
  input wire logic           supply_ok,
  input wire logic [NCH-1:0] pwm_enable,
  input wire logic           cfg_other,
  input wire logic           shared_fault_cfg_pin_i,
  // Outputs
  input wire logic [NCH-1:0] fault_out_lines_n,
  input wire logic [NCH-1:0] stage_drive_en,
  input wire logic [1:0]     cfg_mode,
  input wire logic           shared_fault_cfg_pin_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // Quiet lead-in so no older event is still in the filter
    sequence s_spike;
      (!oc_high[c] && !temp_crit && supply_ok)[*8] ##0 stage_drive_en[c]
        ##1 oc_high[c]
        ##1 (!oc_high[c] && pwm_enable[c] && supply_ok && !temp_crit)[*8];
    endsequence
    AST_SPIKE: assert property (s_spike |-> stage_drive_en[c])
      else $error("short spike shut a stage");
    AST_HIGH_LATCH: assert property (stage_drive_en[c] ##0
      (oc_high[c] && supply_ok)[*8] |->
      ##[1:3] (!fault_out_lines_n[c] && !stage_drive_en[c]))
      else $error("high overcurrent not latched");
    AST_HIGH_HOLD: assert property (supply_ok[*6] ##0
      (!fault_out_lines_n[c] && !stage_drive_en[c] && pwm_enable[c])
      |=> !fault_out_lines_n[c])
      else $error("latched fault released without ack");
    AST_LOW_FAULT: assert property (stage_drive_en[c] ##0
      (oc_low[c] && supply_ok)[*8] |-> ##[1:3] !fault_out_lines_n[c])
      else $error("low overcurrent not reported");
    AST_LOW_KEEP: assert property (
      (pwm_enable[c] && !oc_high[c] && !temp_crit && supply_ok)[*8]
      ##0 stage_drive_en[c] |=> stage_drive_en[c])
      else $error("stage shut without a hard fault");
  end
  AST_UV_ALL: assert property ((!supply_ok)[*4] |->
    (fault_out_lines_n == '0 && stage_drive_en == '0))
    else $error("undervoltage not reported on all lines");
  AST_THERM_ALL: assert property ((stage_drive_en != '0) ##0
    (temp_crit && supply_ok)[*8] |->
    ##[1:3] (fault_out_lines_n == '0 && stage_drive_en == '0))
    else $error("over-temperature did not shut all stages");
  AST_QUIET: assert property ((pwm_enable == '0 && oc_high == '0 &&
    oc_low == '0 && !temp_crit && supply_ok)[*8] |->
    ##2 fault_out_lines_n == '1)
    else $error("fault kept after drive was turned off");
  AST_PIN_RESET: assert property (disable iff (1'b0)
    !rst_n |=> shared_fault_cfg_pin_oe_n)
    else $error("shared pin driven during reset");
  AST_CFG: assert property ($rose(rst_n) |=>
    cfg_mode == {$past(shared_fault_cfg_pin_i), $past(cfg_other)})
    else $error("configuration strap not captured");
endmodule

bind amp_fault_protection amp_fault_asserts #(.NCH(NCH)) amp_fault_asserts_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .oc_low(oc_low), .oc_high(oc_high),
  .temp_crit(temp_crit), .supply_ok(supply_ok), .pwm_enable(pwm_enable),
  .cfg_other(cfg_other), .shared_fault_cfg_pin_i(shared_fault_cfg_pin_i),
  .fault_out_lines_n(fault_out_lines_n), .stage_drive_en(stage_drive_en),
  .cfg_mode(cfg_mode), .shared_fault_cfg_pin_oe_n(shared_fault_cfg_pin_oe_n)
);
`default_nettype wire

// file: test/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// System controller and board wiring
// ----
module ctrl_model (
  // Clock
  input wire logic        clk_sys,
  // Bench commands
  input wire logic [3:0]  pwm_req,
  input wire logic        ack_en,
  input wire logic [1:0]  mode,
  // Device side
  input wire logic [3:0]  fault_n,
  output var logic [3:0]  pwm_enable,
  output var logic [2:0]  sense_n
);
  // Ack drops only the faulty channel, so others keep playing
  always @(posedge clk_sys) pwm_enable <= pwm_req & ~({4{ack_en}} & ~fault_n);
  // Fault lines wired to sense inputs as the output mode needs
  assign sense_n[0] = mode[1] ? fault_n[0] : &fault_n[1:0];
  assign sense_n[1] = mode[1] ? fault_n[1] : &fault_n[3:2];
  assign sense_n[2] = mode[1] ? &fault_n[3:2] : 1'b1;
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Testbench
// ----
module tb;
  logic       clk_sys, rst_n, temp_warn, temp_crit, supply_ok, busy;
  logic       cfg_other, strap, ack_en, pin_i, pin_o, pin_oe_n, warn;
  logic [3:0] oc_low, oc_high, pwm_req, pwm_enable, lines_n, drive;
  logic [2:0] sense_n, gain;
  logic [1:0] cfg_mode;
  int         fails, compares;
  // Pin level: strap resistor unless the device pulls low
  assign pin_i = pin_oe_n ? strap : pin_o;
  amp_fault_protection #(.INIT_CYC(8), .REL_CYC(50)) amp_fault_protection_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .oc_low(oc_low), .oc_high(oc_high),
    .temp_warn(temp_warn), .temp_crit(temp_crit), .supply_ok(supply_ok),
    .pwm_enable(pwm_enable), .bus_master_busy(busy), .cfg_other(cfg_other),
    .fault_out_lines_n(lines_n), .fault_sense_group_n(sense_n),
    .shared_fault_cfg_pin_i(pin_i), .shared_fault_cfg_pin_o(pin_o),
    .shared_fault_cfg_pin_oe_n(pin_oe_n), .stage_drive_en(drive),
    .cfg_mode(cfg_mode), .gain_step(gain), .thermal_warn_flag(warn));
  ctrl_model ctrl_model_i (
    .clk_sys(clk_sys), .pwm_req(pwm_req), .ack_en(ack_en),
    .mode({strap, cfg_other}), .fault_n(lines_n),
    .pwm_enable(pwm_enable), .sense_n(sense_n));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait on lines (sel 0) or stage drive (sel 1)
  task automatic wait_for(input bit sel, input logic [3:0] e);
    int k;
    for (k = 0; k < 60; k++) begin
      if ((sel ? drive : lines_n) === e) break;
      cyc(1);
    end
    compares++;
    if (k == 60) begin
      fails++;
      $display("[FAIL] %0t wait ran out", $time);
      test_done();
    end
  endtask
  task automatic t_reset();
    @(posedge clk_sys) rst_n <= 1'b0;
    cyc(2);
    chk(pin_oe_n, 1'b1);
    @(posedge clk_sys) rst_n <= 1'b1;
    cyc(3);
    chk(cfg_mode, {strap, cfg_other});
    @(posedge clk_sys) busy <= 1'b1;
    cyc(3);
    chk({pin_oe_n, pin_o}, 2'h0);
    chk(drive, 4'h0);
    @(posedge clk_sys) busy <= 1'b0;
    wait_for(1'b1, 4'hf);
    chk(pin_oe_n, 1'b1);
  endtask
  task automatic t_gain();
    logic [2:0] g;
    chk(gain, 3'h0);
    @(posedge clk_sys) temp_warn <= 1'b1;
    cyc(8);
    chk({warn, gain, drive}, 8'haf);
    @(posedge clk_sys) temp_warn <= 1'b0;
    @(posedge clk_sys) oc_low[0] <= 1'b1;
    cyc(60);
    @(posedge clk_sys) oc_low[0] <= 1'b0;
    cyc(15);
    g = gain;
    chk(g > 3'h1, 1'b1);
    cyc(60);
    chk(gain, g - 3'h1);
    @(posedge clk_sys) temp_warn <= 1'b1;
    cyc(8);
    chk({warn, gain >= 3'h2, drive}, 6'h3f);
    @(posedge clk_sys) temp_warn <= 1'b0;
  endtask
  task automatic t_low();
    @(posedge clk_sys) oc_low[1] <= 1'b1;
    wait_for(1'b0, 4'hd);
    cyc(5);
    chk({drive, lines_n}, 8'hfd);
    @(posedge clk_sys) oc_low[1] <= 1'b0;
    wait_for(1'b0, 4'hf);
    @(posedge clk_sys) oc_high[2] <= 1'b1;
    @(posedge clk_sys) oc_high[2] <= 1'b0;
    cyc(12);
    chk({drive, lines_n}, 8'hff);
  endtask
  task automatic t_high(input int c);
    logic [3:0] m;
    m = ~(4'h1 << c);
    @(posedge clk_sys) oc_high[c] <= 1'b1;
    wait_for(1'b0, m);
    chk({pin_oe_n, drive}, {1'b0, m});
    @(posedge clk_sys) oc_high[c] <= 1'b0;
    cyc(15);
    chk(lines_n, m);
    @(posedge clk_sys) ack_en <= 1'b1;
    wait_for(1'b0, 4'hf);
    wait_for(1'b1, 4'hf);
    @(posedge clk_sys) ack_en <= 1'b0;
  endtask
  task automatic t_therm();
    @(posedge clk_sys) temp_crit <= 1'b1;
    wait_for(1'b0, 4'h0);
    cyc(8);
    @(posedge clk_sys) temp_crit <= 1'b0;
    cyc(10);
    chk({drive, lines_n}, 8'h00);
    @(posedge clk_sys) pwm_req <= 4'h0;
    wait_for(1'b0, 4'hf);
    cyc(10);
    @(posedge clk_sys) pwm_req <= 4'hf;
    wait_for(1'b1, 4'hf);
  endtask
  task automatic t_mode();
    @(posedge clk_sys) oc_low[3] <= 1'b1;
    wait_for(1'b0, 4'h7);
    cyc(4);
    chk(gain, 3'h1);
    @(posedge clk_sys) oc_low[3] <= 1'b0;
    wait_for(1'b0, 4'hf);
  endtask
  task automatic t_uv();
    @(posedge clk_sys) supply_ok <= 1'b0;
    cyc(4);
    chk({drive, lines_n}, 8'h00);
    @(posedge clk_sys) supply_ok <= 1'b1;
    cyc(3);
    chk(drive, 4'h0);
    wait_for(1'b1, 4'hf);
  endtask
  initial begin
    fails = 0;
    compares = 0;
    rst_n = 1'b0;
    oc_low = 4'h0;
    oc_high = 4'h0;
    temp_warn = 1'b0;
    temp_crit = 1'b0;
    supply_ok = 1'b1;
    busy = 1'b0;
    cfg_other = 1'b1;
    strap = 1'b1;
    ack_en = 1'b0;
    pwm_req = 4'hf;
    t_reset();
    t_gain();
    t_low();
    for (int c = 0; c < 4; c++) t_high(c);
    t_therm();
    t_uv();
    @(posedge clk_sys) strap <= 1'b0;
    t_reset();
    t_mode();
    test_done();
  end
endmodule
`default_nettype wire
